// ### regfile_cfg.svh
// Constants for the working register file and its operand path
// Summary of operation
// - Thirty-two eight-bit registers, single-cycle access.
// - Two operands read, result written same cycle.
// - Six registers form three 16-bit pointers.
// - One pointer addresses program-memory constant lookups.
// - Data addresses 00..1F reach the registers.
// - Register-register, immediate-register and single-register operations.
// - Pointers built from registers twenty-six to thirty-one.
// - Immediate operations limited to upper register half.
// - Pre-decrement and post-increment update the pointer.
`ifndef REGFILE_CFG_SVH
`define REGFILE_CFG_SVH
`define RF_REG_COUNT     32
`define RF_DATA_WIDTH    8
`define RF_ADDR_WIDTH    16
`define RF_IDX_WIDTH     5
`define RF_PTR_BASE      5'h1A
`define RF_UPPER_BASE    5'h10
`define RF_MAP_LAST      16'h001F
`define RF_LOOKUP_PTR    2'h2
`define RF_RESET_VALUE   8'h00
`endif

// ### regfile_pkg.sv
// Types shared by the register file and its users
package regfile_pkg;
    typedef enum logic [2:0] {
        OP_ADD = 3'h0,
        OP_SUB = 3'h1,
        OP_AND = 3'h2,
        OP_OR  = 3'h3,
        OP_XOR = 3'h4,
        OP_MOV = 3'h5,
        OP_INC = 3'h6,
        OP_DEC = 3'h7
    } alu_op_e;

    typedef enum logic [1:0] {
        SRC_REG  = 2'h0,
        SRC_IMM  = 2'h1,
        SRC_NONE = 2'h2
    } operand_src_e;

    typedef enum logic [1:0] {
        PTR_NONE = 2'h0,
        PTR_POSTINC = 2'h1,
        PTR_PREDEC = 2'h2
    } ptr_mode_e;

    typedef struct packed {
        logic         valid;
        alu_op_e      op;
        operand_src_e src;
        logic [4:0]   dst;
        logic [4:0]   srcReg;
        logic [7:0]   imm;
    } alu_req_s;

    typedef struct packed {
        logic       valid;
        logic [1:0] sel;
        ptr_mode_e  mode;
    } ptr_req_s;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_req_s;
endpackage

// ### cpu_register_file_alu.sv
// Working register file with single-cycle operand path and pointer pairs
`timescale 1ns/100ps
`default_nettype none
`include "regfile_cfg.svh"
module cpu_register_file_alu #(
    parameter int REG_COUNT = `RF_REG_COUNT
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // Decoder and operand path
    input  wire regfile_pkg::alu_req_s aluReq,
    output logic [7:0]                aluResult,
    output logic                      aluRefused,
    // Pointer address path
    input  wire regfile_pkg::ptr_req_s ptrReq,
    output logic [15:0]               ptrAddr,
    output logic [15:0]               lookupAddr,
    // Data-space load and store path
    input  wire regfile_pkg::mem_req_s memReq,
    output logic                      memHit,
    output logic [7:0]                memRdata
);
    import regfile_pkg::*;

    // Register file storage and registered outputs
    logic [7:0] regs_reg [REG_COUNT];
    logic [7:0] regs_next [REG_COUNT];
    logic [7:0] aluResult_reg, aluResult_next;
    logic [7:0] memRdata_reg, memRdata_next;
    logic       refused_reg, refused_next;
    logic [7:0] opA, opB, res;
    logic       immOk, aluWr, memSel;
    logic [4:0] ptrLo;
    logic [15:0] ptrCur, ptrNew;

    // Operands straight from the file, opB from imm for SRC_IMM; both read in the same cycle
    assign opA = regs_reg[aluReq.dst];
    assign opB = (aluReq.src == SRC_IMM) ? aluReq.imm : regs_reg[aluReq.srcReg];
    assign immOk = (aluReq.src != SRC_IMM) || aluReq.dst[4];
    assign aluWr = aluReq.valid && immOk;
    assign memSel = (memReq.addr <= `RF_MAP_LAST);

    always_comb begin
        unique case (aluReq.op)
            OP_ADD: res = opA + opB;
            OP_SUB: res = opA - opB;
            OP_AND: res = opA & opB;
            OP_OR:  res = opA | opB;
            OP_XOR: res = opA ^ opB;
            OP_MOV: res = opB;
            OP_INC: res = opA + 8'h01;
            OP_DEC: res = opA - 8'h01;
        endcase
    end

    // Pointer pair: low byte in lower register
    assign ptrLo  = `RF_PTR_BASE + {2'h0, ptrReq.sel, 1'b0};
    assign ptrCur = {regs_reg[ptrLo + 5'h01], regs_reg[ptrLo]};
    always_comb begin
        unique case (ptrReq.mode)
            PTR_POSTINC: ptrNew = ptrCur + 16'h0001;
            PTR_PREDEC:  ptrNew = ptrCur - 16'h0001;
            default:     ptrNew = ptrCur;
        endcase
    end
    assign ptrAddr = (ptrReq.mode == PTR_PREDEC) ? ptrNew : ptrCur;
    assign lookupAddr = {regs_reg[`RF_PTR_BASE + 5'h05], regs_reg[`RF_PTR_BASE + 5'h04]};

    // Next state: ALU writeback, then pointer update, then memory store
    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            regs_next[i] = regs_reg[i];
        end
        if (aluWr) begin
            regs_next[aluReq.dst] = res;
        end
        if (ptrReq.valid && ptrReq.mode != PTR_NONE) begin
            regs_next[ptrLo] = ptrNew[7:0];
            regs_next[ptrLo + 5'h01] = ptrNew[15:8];
        end
        if (memReq.wr && memSel) begin
            regs_next[memReq.addr[4:0]] = memReq.wdata;
        end
        // Result and read data hold until the next accepted access
        aluResult_next = aluWr ? res : aluResult_reg;
        refused_next = aluReq.valid && !immOk;
        memRdata_next = (memReq.rd && memSel) ? regs_reg[memReq.addr[4:0]] : memRdata_reg;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // Whole file clears on reset
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_reg[i] <= `RF_RESET_VALUE;
            end
            aluResult_reg <= 8'h00;
            memRdata_reg  <= 8'h00;
            refused_reg   <= 1'b0;
        end else begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_reg[i] <= regs_next[i];
            end
            aluResult_reg <= aluResult_next;
            memRdata_reg  <= memRdata_next;
            refused_reg   <= refused_next;
        end
    end

    // Outputs straight from flops, except memHit and ptrAddr, which decode their requests combinationally
    assign aluResult  = aluResult_reg;
    assign aluRefused = refused_reg;
    assign memRdata   = memRdata_reg;
    assign memHit     = memSel;

    // Operand path and writeback
    a_alu_writeback: assert property (@(posedge clk_sys) disable iff (rst)
        (aluWr && !(ptrReq.valid && ptrReq.mode != PTR_NONE) && !memReq.wr)
        |=> regs_reg[$past(aluReq.dst)] == $past(res))
        else $error("ALU result not written back");

    a_result_value: assert property (@(posedge clk_sys) disable iff (rst)
        aluWr |=> aluResult == $past(res))
        else $error("ALU result output wrong");

    a_result_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !aluWr |=> $stable(aluResult))
        else $error("ALU result changed without an operation");

    a_add_value: assert property (@(posedge clk_sys) disable iff (rst)
        (aluWr && aluReq.op == OP_ADD && aluReq.src == SRC_REG)
        |=> aluResult == $past(regs_reg[aluReq.dst]) + $past(regs_reg[aluReq.srcReg]))
        else $error("Register add wrong");

    a_sub_value: assert property (@(posedge clk_sys) disable iff (rst)
        (aluWr && aluReq.op == OP_SUB && aluReq.src == SRC_REG)
        |=> aluResult == $past(regs_reg[aluReq.dst]) - $past(regs_reg[aluReq.srcReg]))
        else $error("Register subtract wrong");

    a_and_value: assert property (@(posedge clk_sys) disable iff (rst)
        (aluWr && aluReq.op == OP_AND && aluReq.src == SRC_REG)
        |=> aluResult == ($past(regs_reg[aluReq.dst]) & $past(regs_reg[aluReq.srcReg])))
        else $error("Register and wrong");

    a_or_value: assert property (@(posedge clk_sys) disable iff (rst)
        (aluWr && aluReq.op == OP_OR && aluReq.src == SRC_REG)
        |=> aluResult == ($past(regs_reg[aluReq.dst]) | $past(regs_reg[aluReq.srcReg])))
        else $error("Register or wrong");

    a_xor_value: assert property (@(posedge clk_sys) disable iff (rst)
        (aluWr && aluReq.op == OP_XOR && aluReq.src == SRC_REG)
        |=> aluResult == ($past(regs_reg[aluReq.dst]) ^ $past(regs_reg[aluReq.srcReg])))
        else $error("Register xor wrong");

    a_inc_value: assert property (@(posedge clk_sys) disable iff (rst)
        (aluWr && aluReq.op == OP_INC)
        |=> aluResult == $past(regs_reg[aluReq.dst]) + 8'h01)
        else $error("Single register increment wrong");

    a_dec_value: assert property (@(posedge clk_sys) disable iff (rst)
        (aluWr && aluReq.op == OP_DEC)
        |=> aluResult == $past(regs_reg[aluReq.dst]) - 8'h01)
        else $error("Single register decrement wrong");

    // Immediate operands and the upper register half
    a_mov_imm_value: assert property (@(posedge clk_sys) disable iff (rst)
        (aluWr && aluReq.op == OP_MOV && aluReq.src == SRC_IMM)
        |=> aluResult == $past(aluReq.imm))
        else $error("Immediate load wrong");

    a_sub_imm_value: assert property (@(posedge clk_sys) disable iff (rst)
        (aluWr && aluReq.op == OP_SUB && aluReq.src == SRC_IMM)
        |=> aluResult == $past(regs_reg[aluReq.dst]) - $past(aluReq.imm))
        else $error("Immediate subtract wrong");

    a_imm_lower_block: assert property (@(posedge clk_sys) disable iff (rst)
        (aluReq.valid && aluReq.src == SRC_IMM && !aluReq.dst[4]) |=> aluRefused)
        else $error("Immediate to lower register not refused");

    a_refuse_no_write: assert property (@(posedge clk_sys) disable iff (rst)
        (aluReq.valid && aluReq.src == SRC_IMM && !aluReq.dst[4] && !ptrReq.valid && !memReq.wr)
        |=> regs_reg[$past(aluReq.dst)] == $past(regs_reg[aluReq.dst]))
        else $error("Refused immediate changed a register");

    a_refuse_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        !(aluReq.valid && aluReq.src == SRC_IMM && !aluReq.dst[4]) |=> !aluRefused)
        else $error("Refusal raised without cause");

    // Data-space window onto the file
    a_map_read: assert property (@(posedge clk_sys) disable iff (rst)
        (memReq.rd && memReq.addr < 16'h0020) |=> memRdata == $past(regs_reg[memReq.addr[4:0]]))
        else $error("Mapped read wrong");

    a_map_write: assert property (@(posedge clk_sys) disable iff (rst)
        (memReq.wr && memSel) |=> regs_reg[$past(memReq.addr[4:0])] == $past(memReq.wdata))
        else $error("Mapped write lost");

    a_unmapped_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !(memReq.rd && memSel) |=> $stable(memRdata))
        else $error("Read data changed without a mapped read");

    // Pointer pairs
    a_ptr_base: assert property (@(posedge clk_sys) disable iff (rst)
        ptrLo >= 5'h1A && !ptrLo[0])
        else $error("Pointer outside group");

    a_postinc_addr: assert property (@(posedge clk_sys) disable iff (rst)
        (ptrReq.mode == PTR_POSTINC) |-> ptrAddr == {regs_reg[ptrLo + 5'h01], regs_reg[ptrLo]})
        else $error("Post-increment address wrong");

    a_predec_addr: assert property (@(posedge clk_sys) disable iff (rst)
        (ptrReq.mode == PTR_PREDEC) |-> ptrAddr == {regs_reg[ptrLo + 5'h01], regs_reg[ptrLo]} - 16'h0001)
        else $error("Pre-decrement address wrong");

    a_postinc_step: assert property (@(posedge clk_sys) disable iff (rst)
        (ptrReq.valid && ptrReq.mode == PTR_POSTINC && !aluWr && !memReq.wr)
        |=> ptrCur == $past(ptrCur) + 16'h0001 || $past(ptrReq.sel) != ptrReq.sel)
        else $error("Pointer not incremented");

    a_predec_step: assert property (@(posedge clk_sys) disable iff (rst)
        (ptrReq.valid && ptrReq.mode == PTR_PREDEC && !aluWr && !memReq.wr)
        |=> {regs_reg[$past(ptrLo) + 5'h01], regs_reg[$past(ptrLo)]} == $past(ptrCur) - 16'h0001)
        else $error("Pointer not decremented");

    a_lookup_pair: assert property (@(posedge clk_sys) disable iff (rst)
        lookupAddr == {regs_reg[31], regs_reg[30]})
        else $error("Lookup pointer wrong");
endmodule
`default_nettype wire

// ### lsu_model.sv
// Load/store path model driving the data-space request
`timescale 1ns/100ps
`default_nettype none
module lsu_model (
    // Request from bench
    input  wire logic                   en,
    input  wire logic                   we,
    input  wire logic [15:0]            addr,
    input  wire logic [7:0]             wdata,
    // Data-space request
    output wire regfile_pkg::mem_req_s  memReq
);
    import regfile_pkg::*;
    // Unselected store data is inverted so stale bytes never look valid
    assign memReq = '{rd: en & ~we, wr: en & we, addr: addr, wdata: (en ? wdata : ~wdata)};
endmodule
`default_nettype wire

// ### test_cpu_register_file_alu.sv
// Self-checking bench for the register file and operand path
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %0h got %0h", n, e, a); end end
module test_cpu_register_file_alu;
    import regfile_pkg::*;
    logic clk_sys = 0, rst = 1, memEn = 0, memWe = 0, aluRefused, memHit;
    logic [15:0] memAddr = '0, ptrAddr, lookupAddr;
    logic [7:0] memWd = '0, aluResult, memRdata;
    alu_req_s aluReq = '0;
    ptr_req_s ptrReq = '0;
    mem_req_s memReq;
    int n_fail = 0, total_checks = 0;
    lsu_model lsu (.en(memEn), .we(memWe), .addr(memAddr), .wdata(memWd), .memReq(memReq));
    cpu_register_file_alu dut (.clk_sys(clk_sys), .rst(rst), .aluReq(aluReq),
        .aluResult(aluResult), .aluRefused(aluRefused), .ptrReq(ptrReq), .ptrAddr(ptrAddr),
        .lookupAddr(lookupAddr), .memReq(memReq), .memHit(memHit), .memRdata(memRdata));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic mem(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        memEn <= 1'b1; memWe <= w; memAddr <= a; memWd <= d;
        @(posedge clk_sys);
        memEn <= 1'b0;
        #1;
    endtask
    task automatic alu(input alu_op_e op, input operand_src_e s, input logic [4:0] d,
                       input logic [4:0] r, input logic [7:0] imm);
        @(posedge clk_sys);
        aluReq <= '{1'b1, op, s, d, r, imm};
        @(posedge clk_sys);
        aluReq <= '0;
        #1;
    endtask
    task automatic ptr(input logic [1:0] sel, input ptr_mode_e m, input logic [15:0] e);
        @(posedge clk_sys);
        ptrReq <= '{1'b1, sel, m};
        #1;
        `CHK("ptrAddr", e, ptrAddr)
        @(posedge clk_sys);
        ptrReq <= '0;
        #1;
    endtask
    task automatic t_alu;
        mem(1, 16'h0004, 8'h25);
        mem(1, 16'h0003, 8'h10);
        alu(OP_ADD, SRC_REG, 5'h03, 5'h04, 8'h00);
        `CHK("add", 8'h35, aluResult)
        mem(0, 16'h0003, 8'h00);
        `CHK("r3", 8'h35, memRdata)
        alu(OP_INC, SRC_NONE, 5'h00, 5'h00, 8'h00);
        `CHK("inc r0", 8'h01, aluResult)
        $display("test alu done");
    endtask
    task automatic t_imm;
        alu(OP_MOV, SRC_IMM, 5'h10, 5'h00, 8'hA5);
        `CHK("refused r16", 1'b0, aluRefused)
        `CHK("mov r16", 8'hA5, aluResult)
        alu(OP_MOV, SRC_IMM, 5'h0F, 5'h00, 8'h5A);
        `CHK("refused r15", 1'b1, aluRefused)
        mem(0, 16'h000F, 8'h00);
        `CHK("r15", 8'h00, memRdata)
        $display("test imm done");
    endtask
    task automatic t_ops;
        alu(OP_SUB, SRC_REG, 5'h03, 5'h04, 8'h00);
        `CHK("sub", 8'h10, aluResult)
        `CHK("refused drop", 1'b0, aluRefused)
        alu(OP_OR, SRC_REG, 5'h03, 5'h04, 8'h00);
        `CHK("or", 8'h35, aluResult)
        alu(OP_AND, SRC_REG, 5'h03, 5'h04, 8'h00);
        `CHK("and", 8'h25, aluResult)
        alu(OP_XOR, SRC_REG, 5'h03, 5'h04, 8'h00);
        `CHK("xor", 8'h00, aluResult)
        alu(OP_DEC, SRC_NONE, 5'h03, 5'h00, 8'h00);
        `CHK("dec", 8'hFF, aluResult)
        alu(OP_SUB, SRC_IMM, 5'h10, 5'h00, 8'h05);
        `CHK("sub imm", 8'hA0, aluResult)
        alu(OP_ADD, SRC_IMM, 5'h11, 5'h00, 8'h11);
        `CHK("add imm", 8'h11, aluResult)
        mem(0, 16'h0003, 8'h00);
        `CHK("r3 dec", 8'hFF, memRdata)
        $display("test ops done");
    endtask
    task automatic t_reset;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        `CHK("rst result", 8'h00, aluResult)
        `CHK("rst rdata", 8'h00, memRdata)
        `CHK("rst refused", 1'b0, aluRefused)
        `CHK("rst lookup", 16'h0000, lookupAddr)
        alu(OP_INC, SRC_NONE, 5'h03, 5'h00, 8'h00);
        `CHK("inc after rst", 8'h01, aluResult)
        mem(0, 16'h001F, 8'h00);
        `CHK("r31 rst", 8'h00, memRdata)
        $display("test reset done");
    endtask
    task automatic t_ptr;
        mem(1, 16'h001A, 8'hFF);
        mem(1, 16'h001B, 8'h12);
        ptr(2'h0, PTR_POSTINC, 16'h12FF);
        mem(0, 16'h001A, 8'h00);
        `CHK("r26", 8'h00, memRdata)
        mem(0, 16'h001B, 8'h00);
        `CHK("r27", 8'h13, memRdata)
        ptr(2'h1, PTR_PREDEC, 16'hFFFF);
        mem(0, 16'h001D, 8'h00);
        `CHK("r29", 8'hFF, memRdata)
        mem(1, 16'h001E, 8'h34);
        mem(1, 16'h001F, 8'h56);
        `CHK("lookup", 16'h5634, lookupAddr)
        $display("test ptr done");
    endtask
    task automatic t_map;
        @(posedge clk_sys);
        memAddr <= 16'h0020;
        #1;
        `CHK("hit 20", 1'b0, memHit)
        @(posedge clk_sys);
        memAddr <= 16'h001F;
        #1;
        `CHK("hit 1F", 1'b1, memHit)
        mem(1, 16'h0020, 8'h77);
        mem(0, 16'h001F, 8'h00);
        `CHK("r31", 8'h56, memRdata)
        $display("test map done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_alu();
        t_imm();
        t_ops();
        t_ptr();
        t_map();
        t_reset();
        results();
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        n_fail++;
        results();
    end
endmodule
`default_nettype wire
